// ==== design/alias_decode_pkg.sv ====
// package: address map, alias bit and protection constants for the alias decoder
package alias_decode_pkg;
  localparam int ADDR_W = 32;
  localparam int ALIAS_BIT = 28;
  localparam logic [3:0] CODE_TOP = 4'h1;
  localparam logic [3:0] SRAM_TOP = 4'h2;
  localparam logic [3:0] PERI_TOP = 4'h4;
  localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
  localparam logic [31:0] FLASH_END = 32'h0003_FFFF;
  localparam logic [31:0] ROM_BASE = 32'h0300_0000;
  localparam logic [31:0] ROM_END = 32'h0301_FFFF;
  localparam logic [31:0] SRAMX_BASE = 32'h0400_0000;
  localparam logic [31:0] SRAMX_END = 32'h0400_3FFF;
  localparam logic [31:0] SRAM0_BASE = 32'h2000_0000;
  localparam logic [31:0] SRAM0_END = 32'h2000_7FFF;
  localparam logic [31:0] SRAM1_END = 32'h2000_BFFF;
  localparam logic [31:0] SRAM2_END = 32'h2000_FFFF;
  localparam logic [31:0] USBRAM_END = 32'h2001_3FFF;
  localparam logic [31:0] APB_BASE = 32'h4000_0000;
  localparam logic [31:0] APB_END = 32'h4003_FFFF;
  localparam logic [31:0] AHBP_BASE = 32'h4008_0000;
  localparam logic [31:0] AHBP_END = 32'h400A_FFFF;
  localparam int N_REGIONS = 8;
  localparam int N_SUBREG = 8;
  localparam int PAGE_BYTES = 512;
  localparam int RSVD_PAGES = 17;
  localparam logic [31:0] FLASH_RSVD_BYTES = 32'(RSVD_PAGES * PAGE_BYTES);
  // target select encoding
  typedef enum logic [3:0] {
    TGT_NONE, TGT_FLASH, TGT_ROM, TGT_SRAMX, TGT_SRAM0, TGT_SRAM1,
    TGT_SRAM2, TGT_USBRAM, TGT_APB, TGT_AHBP
  } target_t;
  // region access permission
  typedef enum logic [1:0] {
    PERM_NONE, PERM_RO, PERM_RW
  } perm_t;
endpackage : alias_decode_pkg

// ==== design/prot_check.sv ====
// module: region protection and security attribution checker
`timescale 1ns/1ps
`default_nettype none
module prot_check
  import alias_decode_pkg::*;
#(
  parameter int NREG = N_REGIONS
) (
  // access under check
  input wire logic [ADDR_W-1:0] addr,
  input wire logic write,
  input wire logic sec_attr,
  input wire logic nsc_req,
  // region table, flat per region
  input wire logic [NREG-1:0] reg_en,
  input wire logic [NREG*32-1:0] reg_base,
  input wire logic [NREG*5-1:0] reg_size_log2,
  input wire logic [NREG*8-1:0] reg_sub_dis,
  input wire logic [NREG*2-1:0] reg_perm,
  input wire logic [NREG-1:0] reg_nsc,
  // result
  output logic allow
);
  logic [NREG-1:0] hit;
  logic [NREG-1:0] ok;

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      logic [31:0] mask;
      logic [4:0] sz;
      logic [2:0] sub;
      logic [31:0] off;
      assign sz = reg_size_log2[g*5 +: 5];
      assign mask = ~((32'h0000_0001 << sz) - 32'h0000_0001);
      assign off = (addr & ~mask) >> ((sz > 5'h03) ? (sz - 5'h03) : 5'h00);
      assign sub = off[2:0];
      // eight equal subregions, each individually excludable
      assign hit[g] = reg_en[g] && ((addr & mask) == (reg_base[g*32 +: 32] & mask))
        && !reg_sub_dis[g*8 + sub];
      // no-access and read-only regions; nsc areas inside secure space
      assign ok[g] = (reg_perm[g*2 +: 2] == 2'(PERM_RW)
        || (reg_perm[g*2 +: 2] == 2'(PERM_RO) && !write))
        && (!nsc_req || (reg_nsc[g] && sec_attr));
    end
  endgenerate

  // lowest matching region wins; no match blocks the access
  always_comb begin
    allow = 1'b0;
    for (int i = NREG - 1; i >= 0; i--) begin
      if (hit[i]) begin
        allow = ok[i];
      end
    end
  end
endmodule : prot_check
`default_nettype wire

// ==== design/alias_decode.sv ====
// module: secure-alias address decoder and router for code and system buses
// Operation
// - code region addresses from zero go out on the code bus
// - addresses from the data region base upward go out on the system bus
// - code and system masters proceed in the same cycle independently
// - address bit 28 marks each access as secure or non-secure
// - target selection ignores bit 28, giving each location two addresses
// - first 256 MB selects flash, boot ROM and code SRAM on code bus
// - SRAM range selects three SRAM banks and USB SRAM on data bus
// - peripheral range selects high-speed and bridged peripherals on data bus
// - both aliases of a resource reach the same target
// - a separate checker, not the decoder, decides permission
// - chosen areas of secure regions may be non-secure callable
// - up to eight regions, each with eight excludable subregions
// - unmatched or forbidden accesses are blocked and raise a fault
// - regions may deny all access or allow reads only
// - last 17 flash pages are reserved on the largest flash
`timescale 1ns/1ps
`default_nettype none
module alias_decode
  import alias_decode_pkg::*;
#(
  parameter int NREG = N_REGIONS,
  parameter bit BIG_FLASH = 1'b1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // code-bus master request
  input wire logic c_valid,
  input wire logic [ADDR_W-1:0] c_addr,
  input wire logic c_write,
  input wire logic c_nsc,
  // system-bus master request
  input wire logic s_valid,
  input wire logic [ADDR_W-1:0] s_addr,
  input wire logic s_write,
  input wire logic s_nsc,
  // protection region table
  input wire logic [NREG-1:0] reg_en,
  input wire logic [NREG*32-1:0] reg_base,
  input wire logic [NREG*5-1:0] reg_size_log2,
  input wire logic [NREG*8-1:0] reg_sub_dis,
  input wire logic [NREG*2-1:0] reg_perm,
  input wire logic [NREG-1:0] reg_nsc,
  // code-bus port toward matrix
  output logic c_go,
  output logic [ADDR_W-1:0] c_out_addr,
  output logic c_out_sec,
  output logic [3:0] c_tgt,
  // system-bus port toward matrix
  output logic s_go,
  output logic [ADDR_W-1:0] s_out_addr,
  output logic s_out_sec,
  output logic [3:0] s_tgt,
  // fault
  output logic mem_fault_q,
  output logic [ADDR_W-1:0] fault_addr_q
);
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  localparam logic [31:0] FLASH_USE_END = BIG_FLASH ?
    (FLASH_END - FLASH_RSVD_BYTES) : FLASH_END;

  // bit 28 stripped before any range compare
  function automatic logic [3:0] decode(input logic [31:0] a);
    logic [31:0] p;
    p = a & ~(32'h0000_0001 << ALIAS_BIT);
    decode = 4'(TGT_NONE);
    if (p[31:28] == 4'h0) begin
      if (p <= FLASH_USE_END) decode = 4'(TGT_FLASH);
      else if (p >= ROM_BASE && p <= ROM_END) decode = 4'(TGT_ROM);
      else if (p >= SRAMX_BASE && p <= SRAMX_END) decode = 4'(TGT_SRAMX);
    end else if (p[31:28] == SRAM_TOP) begin
      if (p <= SRAM0_END) decode = 4'(TGT_SRAM0);
      else if (p <= SRAM1_END) decode = 4'(TGT_SRAM1);
      else if (p <= SRAM2_END) decode = 4'(TGT_SRAM2);
      else if (p <= USBRAM_END) decode = 4'(TGT_USBRAM);
    end else if (p[31:28] == PERI_TOP) begin
      if (p <= APB_END) decode = 4'(TGT_APB);
      else if (p >= AHBP_BASE && p <= AHBP_END) decode = 4'(TGT_AHBP);
    end
  endfunction : decode

  logic [3:0] c_dec;
  logic [3:0] s_dec;
  logic c_code;
  logic s_code;
  logic c_allow;
  logic s_allow;
  assign c_dec = decode(c_addr);
  assign s_dec = decode(s_addr);
  // code region is 0x0000_0000..0x1FFF_FFFF, everything else system
  assign c_code = c_addr[31:29] == 3'h0;
  assign s_code = s_addr[31:29] == 3'h0;

  // ------------------------------------------------------------
  // checking, one independent checker per master
  // ------------------------------------------------------------
  // decoder only forwards bit 28; permission lives in prot_check
  prot_check #(.NREG(NREG)) u_chk_c (
    .addr(c_addr),
    .write(c_write),
    .sec_attr(c_addr[ALIAS_BIT]),
    .nsc_req(c_nsc),
    .reg_en(reg_en),
    .reg_base(reg_base),
    .reg_size_log2(reg_size_log2),
    .reg_sub_dis(reg_sub_dis),
    .reg_perm(reg_perm),
    .reg_nsc(reg_nsc),
    .allow(c_allow)
  );
  prot_check #(.NREG(NREG)) u_chk_s (
    .addr(s_addr),
    .write(s_write),
    .sec_attr(s_addr[ALIAS_BIT]),
    .nsc_req(s_nsc),
    .reg_en(reg_en),
    .reg_base(reg_base),
    .reg_size_log2(reg_size_log2),
    .reg_sub_dis(reg_sub_dis),
    .reg_perm(reg_perm),
    .reg_nsc(reg_nsc),
    .allow(s_allow)
  );

  // ------------------------------------------------------------
  // routing: both ports run in parallel, no arbitration between them
  // ------------------------------------------------------------
  logic c_ok;
  logic s_ok;
  assign c_ok = c_valid && c_code && c_allow && c_dec != 4'(TGT_NONE);
  assign s_ok = s_valid && !s_code && s_allow && s_dec != 4'(TGT_NONE);
  assign c_go = c_ok;
  assign s_go = s_ok;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      c_out_addr <= 32'h0000_0000;
      c_out_sec <= 1'b0;
      c_tgt <= 4'h0;
    end else begin
      c_out_addr <= c_addr;
      c_out_sec <= c_addr[ALIAS_BIT];
      c_tgt <= c_ok ? c_dec : 4'(TGT_NONE);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_out_addr <= 32'h0000_0000;
      s_out_sec <= 1'b0;
      s_tgt <= 4'h0;
    end else begin
      s_out_addr <= s_addr;
      s_out_sec <= s_addr[ALIAS_BIT];
      s_tgt <= s_ok ? s_dec : 4'(TGT_NONE);
    end
  end

  // ------------------------------------------------------------
  // fault: a blocked access pulses the fault for one cycle
  // ------------------------------------------------------------
  logic c_bad;
  logic s_bad;
  // misrouted or undecoded accesses are blocked just like denied ones
  assign c_bad = c_valid && !c_ok;
  assign s_bad = s_valid && !s_ok;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mem_fault_q <= 1'b0;
      fault_addr_q <= 32'h0000_0000;
    end else begin
      mem_fault_q <= c_bad || s_bad;
      if (c_bad) fault_addr_q <= c_addr;
      else if (s_bad) fault_addr_q <= s_addr;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_alias_same_tgt: assert property (@(posedge mclk) disable iff (!rst_n)
    decode(s_addr) == decode(s_addr ^ 32'h1000_0000))
    else $error("aliases decode to different targets");
  a_sec_follows: assert property (@(posedge mclk) disable iff (!rst_n)
    s_valid |=> s_out_sec == $past(s_addr[28]))
    else $error("security attribute not forwarded");
  a_code_only: assert property (@(posedge mclk) disable iff (!rst_n)
    c_go |-> c_addr[31:29] == 3'h0)
    else $error("code port carried non-code address");
  a_sys_only: assert property (@(posedge mclk) disable iff (!rst_n)
    s_go |-> s_addr[31:29] != 3'h0)
    else $error("system port carried code address");
  a_fault_blocked: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_valid && !s_go) |=> mem_fault_q)
    else $error("blocked access raised no fault");
  a_no_region: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_en == '0) |-> !c_go && !s_go)
    else $error("access passed with no region enabled");
  // both ports granted together must both deliver a target on the next edge
  a_parallel_go: assert property (@(posedge mclk) disable iff (!rst_n)
    (c_go && s_go) |=> c_tgt != 4'(TGT_NONE) && s_tgt != 4'(TGT_NONE))
    else $error("masters serialised");
  // reserved tail lies inside the flash window, so it needs its own check
  a_rsvd_flash: assert property (@(posedge mclk) disable iff (!rst_n)
    (BIG_FLASH && c_addr[27:0] > FLASH_USE_END[27:0] && c_addr[27:0] <= FLASH_END[27:0])
    |-> !c_go)
    else $error("reserved flash page decoded");
  a_ro_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (reg_en == 8'h02 && reg_perm[3:2] == 2'(PERM_RO) && s_write) |-> !s_go)
    else $error("write passed a read-only region");
  a_peri_tgt: assert property (@(posedge mclk) disable iff (!rst_n)
    s_go && s_addr[31:28] inside {4'h4, 4'h5} |=> s_tgt inside {4'(TGT_APB), 4'(TGT_AHBP)})
    else $error("peripheral range misdecoded");
endmodule : alias_decode
`default_nettype wire

// ==== tb/bus_master_model.sv ====
// partner model: code and system bus masters that drive the decoder
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
  // clock
  input wire logic mclk,
  // code-bus master
  output logic c_valid,
  output logic [31:0] c_addr,
  output logic c_write,
  output logic c_nsc,
  // system-bus master
  output logic s_valid,
  output logic [31:0] s_addr,
  output logic s_write,
  output logic s_nsc
);
  initial begin
    c_valid = 1'b0;
    c_addr = 32'h0;
    c_write = 1'b0;
    c_nsc = 1'b0;
    s_valid = 1'b0;
    s_addr = 32'h0;
    s_write = 1'b0;
    s_nsc = 1'b0;
  end
  // ----------------------------------------
  // request launch
  // ----------------------------------------
  // idle address and write lines invert so a stale address never passes for a live one
  task automatic issue(input logic cv, input logic [31:0] ca, input logic cw, input logic cn,
      input logic sv, input logic [31:0] sa, input logic sw, input logic sn);
    @(negedge mclk);
    c_valid = cv;
    c_addr = cv ? ca : ~c_addr;
    c_write = cv ? cw : ~c_write;
    c_nsc = cv & cn;
    s_valid = sv;
    s_addr = sv ? sa : ~s_addr;
    s_write = sv ? sw : ~s_write;
    s_nsc = sv & sn;
  endtask : issue
endmodule : bus_master_model
`default_nettype wire

// ==== tb/secure_alias_address_decode_bench.sv ====
// testbench: random and corner-case accesses through the alias decoder
`timescale 1ns/1ps
`default_nettype none
module secure_alias_address_decode_bench import alias_decode_pkg::*;;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic c_valid, c_write, c_nsc, s_valid, s_write, s_nsc;
  logic [31:0] c_addr, s_addr, c_out_addr, s_out_addr, fault_addr_q;
  logic c_go, s_go, c_out_sec, s_out_sec, mem_fault_q;
  logic [3:0] c_tgt, s_tgt;
  logic [255:0] rbase;
  logic [39:0] rsz;
  logic [63:0] rsd;
  logic [15:0] rpm;
  int num_errors = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h7;
  // ----------------------------------------
  // region table and pick table
  // ----------------------------------------
  localparam logic [31:0] RB [8] = '{32'h1400_0000, 32'h2001_0000, 32'h5008_0000, 32'h0,
    32'h2000_0000, 32'h4000_0000, 32'h0300_0000, 32'h0300_0000};
  localparam int RZ [8] = '{14, 16, 16, 29, 29, 29, 17, 17};
  localparam logic [7:0] RD [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00};
  localparam logic [1:0] RP [8] = '{2'h2, 2'h1, 2'h0, 2'h2, 2'h2, 2'h2, 2'h0, 2'h0};
  localparam logic [7:0] REN = 8'h3F;
  localparam logic [7:0] RNC = 8'h01;
  logic [7:0] ren = REN;
  localparam logic [31:0] TB [6] = '{FLASH_BASE, ROM_BASE, SRAMX_BASE, SRAM0_BASE, APB_BASE,
    AHBP_BASE};
  localparam logic [31:0] TS [6] = '{32'h4_0000, 32'h2_0000, 32'h4000, 32'h1_4000, 32'h4_0000,
    32'h3_0000};
  always #50 mclk = ~mclk;
  bus_master_model m (.mclk(mclk), .c_valid(c_valid), .c_addr(c_addr), .c_write(c_write),
    .c_nsc(c_nsc), .s_valid(s_valid), .s_addr(s_addr), .s_write(s_write), .s_nsc(s_nsc));
  alias_decode #(.NREG(8), .BIG_FLASH(1'b1)) dut (.mclk(mclk), .rst_n(rst_n),
    .c_valid(c_valid), .c_addr(c_addr), .c_write(c_write), .c_nsc(c_nsc),
    .s_valid(s_valid), .s_addr(s_addr), .s_write(s_write), .s_nsc(s_nsc),
    .reg_en(ren), .reg_base(rbase), .reg_size_log2(rsz), .reg_sub_dis(rsd), .reg_perm(rpm),
    .reg_nsc(RNC), .c_go(c_go), .c_out_addr(c_out_addr), .c_out_sec(c_out_sec),
    .c_tgt(c_tgt), .s_go(s_go), .s_out_addr(s_out_addr), .s_out_sec(s_out_sec),
    .s_tgt(s_tgt), .mem_fault_q(mem_fault_q), .fault_addr_q(fault_addr_q));
  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [3:0] exp_tgt(logic [31:0] a);
    logic [31:0] p;
    p = a & ~(32'h1 << ALIAS_BIT);
    if (p <= FLASH_END - 32'(RSVD_PAGES * PAGE_BYTES)) return TGT_FLASH;
    if (p >= ROM_BASE && p <= ROM_END) return TGT_ROM;
    if (p >= SRAMX_BASE && p <= SRAMX_END) return TGT_SRAMX;
    if (p >= SRAM0_BASE && p <= SRAM0_END) return TGT_SRAM0;
    if (p > SRAM0_END && p <= SRAM1_END) return TGT_SRAM1;
    if (p > SRAM1_END && p <= SRAM2_END) return TGT_SRAM2;
    if (p > SRAM2_END && p <= USBRAM_END) return TGT_USBRAM;
    if (p >= APB_BASE && p <= APB_END) return TGT_APB;
    if (p >= AHBP_BASE && p <= AHBP_END) return TGT_AHBP;
    return TGT_NONE;
  endfunction : exp_tgt
  // first enabled region that holds the address decides; lower index wins
  function automatic logic exp_ok(logic [31:0] a, logic w, logic n);
    for (int g = 0; g < 8; g++) begin
      if (ren[g] && (a >> RZ[g]) == (RB[g] >> RZ[g]) && !RD[g][a[RZ[g]-1 -: 3]]) begin
        return (RP[g] == 2'h2 || (RP[g] == 2'h1 && !w)) && (!n || (RNC[g] && a[ALIAS_BIT]));
      end
    end
    return 1'b0;
  endfunction : exp_ok
  function automatic logic exp_go(logic v, logic code, logic [31:0] a, logic w, logic n);
    return v && (code == (a < 32'h2000_0000)) && exp_tgt(a) != TGT_NONE && exp_ok(a, w, n);
  endfunction : exp_go
  function automatic logic [31:0] pick(int i, logic [31:0] r);
    logic [31:0] a;
    a = TB[i] + r % TS[i];
    a[ALIAS_BIT] = r[31] && i != 2;
    return a;
  endfunction : pick
  // ----------------------------------------
  // compare, step and closing
  // ----------------------------------------
  task automatic chk_bit(logic got, logic exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t bit got %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_word(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t word got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic step(logic cv, logic [31:0] ca, logic cw, logic cn,
      logic sv, logic [31:0] sa, logic sw, logic sn);
    logic gc;
    logic gs;
    gc = exp_go(cv, 1'b1, ca, cw, cn);
    gs = exp_go(sv, 1'b0, sa, sw, sn);
    m.issue(cv, ca, cw, cn, sv, sa, sw, sn);
    #1;
    chk_bit(c_go, gc);
    chk_bit(s_go, gs);
    @(posedge mclk);
    #1;
    chk_word(32'(c_tgt), gc ? 32'(exp_tgt(ca)) : 32'h0);
    chk_word(32'(s_tgt), gs ? 32'(exp_tgt(sa)) : 32'h0);
    if (cv) chk_bit(c_out_sec, ca[ALIAS_BIT]);
    if (sv) chk_bit(s_out_sec, sa[ALIAS_BIT]);
    if (sv) chk_word(s_out_addr, sa);
    if (cv) chk_word(c_out_addr, ca);
    chk_bit(mem_fault_q, (cv && !gc) || (sv && !gs));
    if ((cv && !gc) || (sv && !gs)) chk_word(fault_addr_q, (cv && !gc) ? ca : sa);
  endtask : step
  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  initial begin
    #(100 * 2000);
    num_errors++;
    close_out();
  end
  initial begin
    logic [31:0] r1, ca, sa, t;
    for (int g = 0; g < 8; g++) begin
      rbase[g*32 +: 32] = RB[g];
      rsz[g*5 +: 5] = 5'(RZ[g]);
      rsd[g*8 +: 8] = RD[g];
      rpm[g*2 +: 2] = RP[g];
    end
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    step(1, 32'h0003_DDFF, 0, 0, 1, 32'h2001_0004, 0, 0);
    step(1, 32'h0003_DE00, 0, 0, 1, 32'h2001_0004, 1, 0);
    step(1, 32'h1400_0010, 0, 1, 1, 32'h5008_0000, 0, 0);
    step(1, 32'h0400_0010, 0, 1, 1, 32'h5000_0100, 0, 0);
    step(1, 32'h1000_0000, 1, 1, 1, 32'h4000_0100, 1, 0);
    step(1, 32'h2000_0000, 0, 0, 1, 32'h0000_0100, 0, 0);
    step(1, 32'h0500_0000, 0, 0, 1, 32'hF000_0000, 0, 0);
    step(1, 32'h0300_0004, 1, 0, 1, 32'h3000_8000, 1, 0);
    step(0, 32'h0, 0, 0, 0, 32'h0, 0, 0);
    @(negedge mclk);
    ren = 8'h00;
    step(1, 32'h0003_0000, 0, 0, 1, 32'h2000_0010, 0, 0);
    @(negedge mclk);
    ren = 8'h02;
    step(1, 32'h0000_0100, 0, 0, 1, 32'h2001_0008, 1, 0);
    step(1, 32'h0000_0100, 0, 0, 1, 32'h2001_0008, 0, 0);
    @(negedge mclk);
    ren = REN;
    for (int k = 0; k < 300; k++) begin
      r1 = rnd();
      ca = pick(int'(r1[7:0] % 3), rnd());
      sa = pick(3 + int'(r1[15:8] % 3), rnd());
      if (r1[20:17] == 4'h0) begin
        t = ca;
        ca = sa;
        sa = t;
      end
      step(r1[21] | r1[22], ca, r1[23], 1'b0, r1[24] | r1[25], sa, r1[26], 1'b0);
    end
    close_out();
  end
endmodule : secure_alias_address_decode_bench
`default_nettype wire
